// ===== pkg/cgr_pkg.sv
// Functional notes
// - guard active drops oscillator edges arriving faster than the guard ceiling
// - guard enable is a static option input, ceiling is a fixed parameter
// - guard enabled starts backup oscillator after first missing main edge
// - divide select 00 gives /1, 01 gives /2, 10 and 11 give /4
// - divider register is write-only, resets to zero, reads back zero
// - internal reset merges pin, power-on, watchdog and low-voltage sources
// - pin low accepted in any mode and holds reset while low
// - internal reset adds delay so short pin pulses give full reset
// - pin reset in run or wait halts, pulls up inputs, restarts oscillator
// - pin reset in stop starts oscillator, pulls up inputs, then initialises
// - power-on keeps reset, pulled-up inputs and no execution
// - after power-on and oscillator running, count delay then initialise
// - watchdog end of count asserts internal reset, reloading the watchdog
// - watchdog reset restarts like pin reset with full delay
// - low-voltage detector holds reset while supply below reference
// - detector falling threshold lower than rising threshold
// - internal reset sources drive the reset pin low
// - main oscillator off bit stops main and starts backup; clear restarts (backup only starts with guard enabled)
// - backup oscillator stops itself once main oscillator runs again
package cgr_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CGR_DIV_CTRL_ADDR = 8'hdc;
	localparam logic [7:0] CGR_STATUS_ADDR = 8'he0;
	localparam logic [7:0] CGR_CTRL_ADDR = 8'he4;
	localparam logic [7:0] CGR_DIV_CTRL_RST = 8'h00;
	localparam int CGR_DIVSEL_LSB = 0;
	localparam int CGR_MAIN_OSC_OFF_BIT = 0;
	localparam int CGR_SWRST_BIT = 1;
	// ****************************************
	// timing
	// ****************************************
	localparam int CGR_STAB_CYCLES = 64;
	localparam int CGR_MISS_CYCLES = 8;
	localparam int CGR_GUARD_MIN_PERIOD = 4;
	localparam int CGR_BACKUP_LOW_FREQ_OSCILLATOR_HALF = 16;
	typedef enum logic [3:0] {
		CGR_ST_RESET = 4'b0001,
		CGR_ST_WAITOSC = 4'b0010,
		CGR_ST_DELAY = 4'b0100,
		CGR_ST_RUN = 4'b1000
	} cgr_state_t;
endpackage

// ===== pkg/cgr_clk_if.sv
interface cgr_clk_if;
	logic guard_en;
	logic osc_off;
	logic main_tick;
	logic main_running;
	logic backup_active;
	logic clk_tick;
	modport guard (input guard_en, osc_off, main_tick,
		output main_running, backup_active, clk_tick);
	modport top (output guard_en, osc_off, main_tick,
		input main_running, backup_active, clk_tick);
endinterface

// ===== rtl/cgr_clock_guard.sv
module cgr_clock_guard
	import cgr_pkg::*;
#(
	parameter int MISS_CYCLES = CGR_MISS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	cgr_clk_if.guard cif
);
	logic [7:0] gap_r;
	logic [7:0] lf_r;
	logic miss_r;
	logic tick_ok;
	// ****************************************
	// spike filter
	// ****************************************
	// edges closer than the ceiling are spikes and dropped
	// gap_r reads one less than the cycles since the last kept edge
	assign tick_ok = cif.main_tick && !cif.osc_off && (!cif.guard_en ||
		gap_r >= 8'(CGR_GUARD_MIN_PERIOD - 1));
	// spikes do not restart the gap, so a fast line is held to the ceiling
	always_ff @(posedge aclk) begin
		if (!aresetn)
			gap_r <= 8'h00;
		else if (tick_ok)
			gap_r <= 8'h00;
		else if (gap_r != 8'hff)
			gap_r <= gap_r + 8'h01;
	end
	// ****************************************
	// missing edge and backup oscillator
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn)
			miss_r <= 1'b1;
		else if (tick_ok)
			miss_r <= 1'b0;
		else if (cif.guard_en && (cif.osc_off ||
			gap_r >= 8'(MISS_CYCLES)))
			miss_r <= 1'b1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !miss_r || !cif.guard_en)
			lf_r <= 8'h00;
		else if (lf_r == 8'(2 * CGR_BACKUP_LOW_FREQ_OSCILLATOR_HALF - 1))
			lf_r <= 8'h00;
		else
			lf_r <= lf_r + 8'h01;
	end
	assign cif.backup_active = cif.guard_en && miss_r;
	assign cif.main_running = !miss_r;
	assign cif.clk_tick = cif.backup_active ? (lf_r == 8'h00) : tick_ok;
endmodule // cgr_clock_guard

// ===== rtl/cgr_top.sv
module cgr_top
	import cgr_pkg::*;
#(
	parameter int STAB_CYCLES = CGR_STAB_CYCLES,
	parameter int MISS_CYCLES = CGR_MISS_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic guard_enable,
	input wire logic lvd_enable,
	input wire logic osc_pin,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic por_pulse,
	input wire logic supply_above_rise,
	input wire logic supply_above_fall,
	input wire logic watchdog_eoc,
	input wire logic stop_mode,
	output logic core_reset,
	output logic io_pullup_inputs,
	output logic init_start,
	output logic watchdog_reload,
	output logic osc_restart,
	output logic internal_clk_en,
	output logic backup_osc_on
);
	cgr_clk_if cif();
	logic [2:0] osc_s_r;
	logic [1:0] rst_s_r;
	logic [1:0] por_s_r;
	logic [1:0] lvr_s_r;
	logic [1:0] lvf_s_r;
	logic [1:0] wd_s_r;
	logic [1:0] stop_s_r;
	logic [1:0] divsel_r;
	logic main_osc_off_r;
	logic swrst_r;
	logic lvd_low_r;
	logic internal_src;
	logic any_src;
	logic [15:0] stab_r;
	logic [1:0] div_cnt_r;
	cgr_state_t state_r;
	logic aw_ok;
	logic w_ok;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic wlane_r;
	logic ar_ok;
	logic [7:0] araddr_r;
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [1:0] div_max(input logic [1:0] sel);
		case (sel)
			2'b00: div_max = 2'd0;
			2'b01: div_max = 2'd1;
			default: div_max = 2'd3;
		endcase
	endfunction
	function automatic logic reg_mapped(input logic [7:0] addr);
		reg_mapped = addr == CGR_DIV_CTRL_ADDR || addr == CGR_STATUS_ADDR ||
			addr == CGR_CTRL_ADDR;
	endfunction
	// ****************************************
	// synchronisers
	// ****************************************
	// every pin but guard_enable and lvd_enable passes two flops before logic reads it
	always_ff @(posedge aclk) begin
		if (!aresetn)
			osc_s_r <= 3'b000;
		else
			osc_s_r <= {osc_s_r[1:0], osc_pin};
	end
	// reset pin idles high, so no false pin reset after release
	always_ff @(posedge aclk) begin
		if (!aresetn)
			rst_s_r <= 2'b11;
		else
			rst_s_r <= {rst_s_r[0], reset_pin_in};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			por_s_r <= 2'b00;
		else
			por_s_r <= {por_s_r[0], por_pulse};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lvr_s_r <= 2'b11;
		else
			lvr_s_r <= {lvr_s_r[0], supply_above_rise};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lvf_s_r <= 2'b11;
		else
			lvf_s_r <= {lvf_s_r[0], supply_above_fall};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			wd_s_r <= 2'b00;
		else
			wd_s_r <= {wd_s_r[0], watchdog_eoc};
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			stop_s_r <= 2'b00;
		else
			stop_s_r <= {stop_s_r[0], stop_mode};
	end
	// ****************************************
	// clock guard
	// ****************************************
	assign cif.guard_en = guard_enable;
	assign cif.osc_off = main_osc_off_r;
	assign cif.main_tick = osc_s_r[1] && !osc_s_r[2];
	cgr_clock_guard #(.MISS_CYCLES(MISS_CYCLES)) u_guard (
		.aclk(aclk),
		.aresetn(aresetn),
		.cif(cif)
	);
	// ****************************************
	// low voltage detector with hysteresis
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lvd_low_r <= 1'b1;
		else if (!lvf_s_r[1])
			lvd_low_r <= 1'b1;
		else if (lvr_s_r[1])
			lvd_low_r <= 1'b0;
	end
	// ****************************************
	// reset merge
	// ****************************************
	assign internal_src = por_s_r[1] || wd_s_r[1] ||
		(lvd_enable && lvd_low_r) || swrst_r;
	// pin held low keeps reset regardless of run, wait or stop
	assign any_src = internal_src || !rst_s_r[1];
	// open drain: pin pulled low while an internal source is active
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = internal_src;
	// ****************************************
	// sequencer
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= CGR_ST_RESET;
			stab_r <= 16'h0000;
		end else if (any_src) begin
			state_r <= CGR_ST_RESET;
			stab_r <= 16'h0000;
		end else begin
			case (state_r)
				CGR_ST_RESET: state_r <= CGR_ST_WAITOSC;
				CGR_ST_WAITOSC: begin
					// delay counts once a clock runs
					if (cif.main_running || cif.backup_active)
						state_r <= CGR_ST_DELAY;
				end
				CGR_ST_DELAY: begin
					if (cif.clk_tick)
						stab_r <= stab_r + 16'h0001;
					if (stab_r == 16'(STAB_CYCLES - 1) && cif.clk_tick)
						state_r <= CGR_ST_RUN;
				end
				CGR_ST_RUN: state_r <= CGR_ST_RUN;
				default: state_r <= CGR_ST_RESET;
			endcase
		end
	end
	assign core_reset = state_r != CGR_ST_RUN;
	assign io_pullup_inputs = core_reset;
	assign osc_restart = state_r == CGR_ST_RESET;
	assign watchdog_reload = core_reset;
	// ****************************************
	// init pulse and divider
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn)
			init_start <= 1'b0;
		else
			init_start <= state_r == CGR_ST_DELAY && !any_src &&
				cif.clk_tick && stab_r == 16'(STAB_CYCLES - 1);
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || core_reset)
			div_cnt_r <= 2'd0;
		else if (cif.clk_tick)
			div_cnt_r <= (div_cnt_r >= div_max(divsel_r)) ?
				2'd0 : div_cnt_r + 2'd1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			internal_clk_en <= 1'b0;
		else
			internal_clk_en <= !core_reset && cif.clk_tick &&
				div_cnt_r >= div_max(divsel_r);
	end
	assign backup_osc_on = cif.backup_active;
	// ****************************************
	// axi4-lite write
	// ****************************************
	assign s_axi_awready = !aw_ok && !s_axi_bvalid;
	assign s_axi_wready = !w_ok && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok <= 1'b0;
			w_ok <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wlane_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok <= 1'b1;
				wdata_r <= s_axi_wstrb[0] ? s_axi_wdata : 32'h0000_0000;
				wlane_r <= s_axi_wstrb[0];
			end
			if (aw_ok && w_ok) begin
				aw_ok <= 1'b0;
				w_ok <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= reg_mapped(awaddr_r) ? 2'b00 : 2'b10;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// lane 0 only; a write without it leaves registers alone
	// strobe kept with the data, the live bus may have moved on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			divsel_r <= CGR_DIV_CTRL_RST[1:0];
			main_osc_off_r <= 1'b0;
			swrst_r <= 1'b0;
		end else if (aw_ok && w_ok && wlane_r && reg_mapped(awaddr_r)) begin
			swrst_r <= 1'b0;
			if (awaddr_r == CGR_DIV_CTRL_ADDR)
				divsel_r <= wdata_r[CGR_DIVSEL_LSB +: 2];
			if (awaddr_r == CGR_CTRL_ADDR) begin
				main_osc_off_r <= wdata_r[CGR_MAIN_OSC_OFF_BIT];
				swrst_r <= wdata_r[CGR_SWRST_BIT];
			end
		end else begin
			swrst_r <= 1'b0;
			if (core_reset)
				main_osc_off_r <= 1'b0;
		end
	end
	// ****************************************
	// axi4-lite read
	// ****************************************
	assign s_axi_arready = !ar_ok && !s_axi_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_ok <= 1'b0;
			araddr_r <= 8'h00;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'b00;
		end else if (s_axi_arvalid && s_axi_arready) begin
			ar_ok <= 1'b1;
			araddr_r <= s_axi_araddr;
		end else if (ar_ok) begin
			ar_ok <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h0000_0000;
			case (araddr_r)
				CGR_DIV_CTRL_ADDR: s_axi_rdata <= 32'h0000_0000;
				CGR_STATUS_ADDR: s_axi_rdata <= {24'h00_0000, lvd_low_r,
					guard_enable, cif.main_running, cif.backup_active,
					state_r};
				CGR_CTRL_ADDR: s_axi_rdata <= {30'h0000_0000, 1'b0,
					main_osc_off_r};
				default: s_axi_rresp <= 2'b10;
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // cgr_top

// ===== sim/cgr_checker.sv
module cgr_checker #(
	parameter int STAB_CYCLES = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic lvd_enable,
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe,
	input wire logic por_pulse,
	input wire logic supply_above_fall,
	input wire logic watchdog_eoc,
	input wire logic core_reset,
	input wire logic io_pullup_inputs,
	input wire logic init_start,
	input wire logic watchdog_reload
);
	// ****************************
	// reset sequencing and bus response properties
	// ****************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_leave;
		core_reset ##1 !core_reset;
	endsequence
	// sync stages allow a few cycles of latency
	a_init_leave: assert property (s_leave |-> ##[0:1] init_start)
		else $error("no init pulse on leaving reset");
	a_init_single: assert property (init_start |=> !init_start)
		else $error("init pulse too long");
	a_init_run: assert property (init_start |-> !core_reset)
		else $error("init while in reset");
	a_pin_reset: assert property (!reset_pin_in |-> ##[0:4] core_reset)
		else $error("pin low without reset");
	a_src_drive: assert property ((por_pulse || watchdog_eoc) |->
		##[0:4] reset_pin_oe && core_reset)
		else $error("internal source not driving pin");
	a_lvd_hold: assert property (lvd_enable && !supply_above_fall |->
		##[0:4] core_reset)
		else $error("low supply without reset");
	a_pin_low: assert property (reset_pin_out == 1'b0)
		else $error("pin driven high");
	a_reset_effects: assert property (io_pullup_inputs == core_reset &&
		watchdog_reload == core_reset)
		else $error("reset effects mismatch");
	a_resp_hold: assert property ((s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid) and (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid))
		else $error("response dropped early");
endmodule // cgr_checker

bind cgr_top cgr_checker #(.STAB_CYCLES(STAB_CYCLES)) cgr_checker_inst (
	.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
	.s_axi_rready, .lvd_enable, .reset_pin_in, .reset_pin_out,
	.reset_pin_oe, .por_pulse, .supply_above_fall, .watchdog_eoc,
	.core_reset, .io_pullup_inputs, .init_start, .watchdog_reload);

// ===== sim/cgr_board.sv
module cgr_board #(
	parameter int RISE = 2100,
	parameter int FALL = 1900
) (
	input wire logic aclk,
	input wire logic btn,
	input wire logic osc_run,
	input wire logic osc_fast,
	input wire logic [11:0] mv,
	input wire logic reset_pin_oe,
	input wire logic reset_pin_out,
	output logic osc_pin,
	output logic reset_pin_in,
	output logic supply_above_rise,
	output logic supply_above_fall
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************
	// oscillator, pin and supply
	// ****************************
	logic ph;
	initial ph = 1'b0;
	initial osc_pin = 1'b0;
	// stopped oscillator stands still; fast mode gives spikes
	always @(posedge aclk) if (osc_run) begin
		ph <= ~ph;
		if (ph || osc_fast)
			osc_pin <= ~osc_pin;
	end
	// pull-up unless button or device pulls low
	assign reset_pin_in = (btn || (reset_pin_oe && !reset_pin_out)) ?
		1'b0 : 1'b1;
	assign supply_above_rise = int'(mv) > RISE;
	assign supply_above_fall = int'(mv) > FALL;
endmodule // cgr_board

// ===== sim/cgr_top_bench.sv
module cgr_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
	logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, q;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic guard_enable, lvd_enable, osc_pin, reset_pin_in, por_pulse;
	logic reset_pin_out, reset_pin_oe, supply_above_rise, stop_mode;
	logic supply_above_fall, watchdog_eoc, core_reset, io_pullup_inputs;
	logic init_start, watchdog_reload, osc_restart, internal_clk_en;
	logic backup_osc_on, btn, osc_run, osc_fast;
	logic [11:0] mv;
	int n_fail, checks_done, c, n;
	cgr_top #(.STAB_CYCLES(4)) cgr_top_inst (.*);
	cgr_board cgr_board_inst (.*);
	// ****************************
	// shared tasks
	// ****************************
	task ck(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	// handshakes judged at negedge, where they are settled
	task xf(input bit w, input logic [7:0] a, input logic [31:0] d);
		logic t1, t2, t3, td;
		@(posedge aclk);
		if (w) begin
			s_axi_awaddr <= a;
			s_axi_wdata <= d;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
		end else begin
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
		end
		do begin
			@(negedge aclk);
			t1 = s_axi_awvalid && s_axi_awready;
			t2 = s_axi_wvalid && s_axi_wready;
			t3 = s_axi_arvalid && s_axi_arready;
			td = w ? s_axi_bvalid : s_axi_rvalid;
			q = s_axi_rdata;
			rs = w ? s_axi_bresp : s_axi_rresp;
			@(posedge aclk);
			if (t1) s_axi_awvalid <= 1'b0;
			if (t2) s_axi_wvalid <= 1'b0;
			if (t3) s_axi_arvalid <= 1'b0;
		end while (td !== 1'b1);
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask
	task cnt;
		n = 0;
		repeat (400) begin
			@(negedge aclk);
			n += (internal_clk_en === 1'b1);
		end
	endtask
	task wi;
		c = 0;
		do begin
			@(negedge aclk);
			c++;
		end while (init_start !== 1'b1 && c < 3000);
		ck("init", 1, init_start);
	endtask
	task conclude;
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ****************************
	// scenarios
	// ****************************
	task t_por;
		repeat (10) @(negedge aclk);
		ck("core_reset", 1, core_reset);
		ck("pin", 0, reset_pin_in);
		@(posedge aclk);
		por_pulse <= 1'b0;
		wi;
		// four ticks of a four-cycle oscillator, minus slack
		ck("delay", 1, c >= 12);
		$display("t_por done");
	endtask
	task t_reg;
		cnt;
		ck("div_rst", 1, n >= 98 && n <= 102);
		xf(0, 8'hdc, 0);
		ck("rd_dc", 0, q);
		xf(1, 8'hdc, 32'h0000_0003);
		ck("wr_resp", 0, rs);
		xf(0, 8'hdc, 0);
		ck("rd_dc2", 0, q);
		xf(0, 8'h40, 0);
		ck("unmapped", 2, rs);
		xf(0, 8'he0, 0);
		ck("status", 32'h0000_0068, q);
		@(posedge aclk);
		s_axi_wstrb <= 4'h0;
		xf(1, 8'he4, 32'h0000_0001);
		s_axi_wstrb <= 4'hf;
		xf(0, 8'he4, 0);
		ck("no_strobe", 0, q);
		$display("t_reg done");
	endtask
	task t_div;
		int e;
		for (int k = 0; k < 4; k++) begin
			xf(1, 8'hdc, k);
			cnt;
			e = 100 >> (k > 1 ? 2 : k);
			ck("div", 1, n >= e - 2 && n <= e + 2);
		end
		osc_fast <= 1'b1;
		xf(1, 8'hdc, 0);
		cnt;
		ck("guard", 1, n >= 98 && n <= 101);
		osc_fast <= 1'b0;
		$display("t_div done");
	endtask
	task t_pin;
		for (int i = 0; i < 2; i++) begin
			@(posedge aclk);
			stop_mode <= i[0];
			btn <= 1'b1;
			repeat (i ? 20 : 1) @(posedge aclk);
			btn <= 1'b0;
			@(negedge aclk);
			if (i) begin
				ck("held", 1, core_reset);
				ck("restart", 1, osc_restart);
				ck("pullup", 1, io_pullup_inputs);
			end
			repeat (6) @(negedge aclk);
			ck("short", 1, core_reset);
			wi;
		end
		$display("t_pin done");
	endtask
	task t_wd;
		@(posedge aclk);
		watchdog_eoc <= 1'b1;
		repeat (6) @(negedge aclk);
		ck("reload", 1, watchdog_reload);
		ck("pin", 0, reset_pin_in);
		@(posedge aclk);
		watchdog_eoc <= 1'b0;
		wi;
		ck("delay", 1, c >= 12);
		$display("t_wd done");
	endtask
	task t_lvd;
		@(posedge aclk);
		mv <= 12'h5dc;
		repeat (6) @(negedge aclk);
		ck("lvd", 1, core_reset);
		@(posedge aclk);
		mv <= 12'h7d0;
		repeat (60) @(negedge aclk);
		ck("hyst_up", 1, core_reset);
		@(posedge aclk);
		mv <= 12'hbb8;
		wi;
		@(posedge aclk);
		mv <= 12'h7d0;
		repeat (20) @(negedge aclk);
		ck("hyst_dn", 0, core_reset);
		@(posedge aclk);
		mv <= 12'hbb8;
		$display("t_lvd done");
	endtask
	task t_osc;
		@(posedge aclk);
		osc_run <= 1'b0;
		repeat (30) @(negedge aclk);
		ck("backup", 1, backup_osc_on);
		@(posedge aclk);
		osc_run <= 1'b1;
		repeat (60) @(negedge aclk);
		ck("backup_off", 0, backup_osc_on);
		xf(1, 8'he4, 1);
		repeat (30) @(negedge aclk);
		ck("osc_off", 1, backup_osc_on);
		xf(0, 8'he4, 0);
		ck("ctrl_rd", 1, q);
		xf(1, 8'he4, 0);
		repeat (60) @(negedge aclk);
		ck("osc_on", 0, backup_osc_on);
		xf(1, 8'he4, 32'h0000_0002);
		@(negedge aclk);
		ck("sw_reset", 1, core_reset);
		wi;
		$display("t_osc done");
	endtask
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		repeat (20000) @(posedge aclk);
		n_fail++;
		conclude;
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, btn, watchdog_eoc} = 4'h0;
		{stop_mode, osc_fast} = 2'h0;
		{guard_enable, lvd_enable, por_pulse, osc_run} = 4'hf;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		mv = 12'hbb8;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_por;
		t_reg;
		t_div;
		t_pin;
		t_wd;
		t_lvd;
		t_osc;
		conclude;
	end
endmodule // cgr_top_bench
